/* File: src/bfs_core.sv */
// Bit, flag and shift execution unit with its APB register file
// Notes on behaviour
// - Overflow-clear branch adds k+1 to PC if V is 0; 1 or 2 cycles.
// - Branch adds k+1 to PC when interrupt flag I is 1; flags kept.
// - Branch adds k+1 to PC when interrupt flag I is 0; flags kept.
// - I/O bit raise/drop forces bit b of location P; flags kept; 2 cycles.
// - Logical shifts fill with zero and update Z, C, N, V in one cycle.
// - Rotates pass the old carry in and the outgoing bit to carry.
// - Arithmetic right shift keeps sign, bit 0 to carry, updates ZCNV.
// - Nibble exchange swaps high and low halves, no flag changes.
// - Generic raise/drop writes 1 or 0 to status bit s only.
// - T store copies register bit b to T; T load copies T to bit b.
// - Dedicated ops set/clear carry, set/clear negative, set/clear zero.
// - Dedicated ops set or clear the global interrupt flag only.
// - Dedicated ops set and clear the signed-test flag only.
// - Dedicated ops set and clear the overflow flag only.
// - Dedicated ops set and clear T and half-carry, each alone.
module bfs_core #(
   parameter int IO_DEPTH = 32  // I/O locations reachable by bit ops
) (
   input  wire logic        I_CLK,     // Core clock, 250 MHz
   input  wire logic        I_RST_B,   // Synchronous reset, active low
   input  wire logic        I_CE,      // Clock enable, freezes all state
   input  wire logic        I_PSEL,    // APB select
   input  wire logic        I_PENABLE, // APB access phase
   input  wire logic        I_PWRITE,  // APB write
   input  wire logic [7:0]  I_PADDR,   // APB byte address
   input  wire logic [31:0] I_PWDATA,  // APB write data
   output logic      [31:0] O_PRDATA,  // APB read data
   output logic             O_PREADY,  // APB ready
   output logic             O_PSLVERR, // APB error on unmapped address
   output logic             O_BUSY     // Operation in progress
);
   bfs_pkg::bfs_st_t  st_q;
   bfs_pkg::bfs_cmd_t cmd_q;
   bfs_pkg::bfs_shf_t shf;
   logic [15:0] pc_q;
   logic [7:0]  sw_q;
   logic [7:0]  opnd_q;
   logic [4:0]  iosel_q;
   logic [7:0]  io_mem_q [IO_DEPTH];
   logic        taken_q;
   logic [1:0]  cyc_q;
   logic [31:0] prdata_q;
   logic [7:0]  flag_sw;
   logic [7:0]  sw_d;
   logic [7:0]  opnd_d;
   logic [15:0] k_ext;
   logic [15:0] pc_tgt;
   logic [15:0] pc_inc;
   logic        taken;
   logic        io_op;
   logic        shf_op;
   logic        two_cyc;
   logic        commit;
   logic        acc;
   logic        wr_ok;
   logic        launch;
   logic [31:0] rd_mux;

   // Register offsets that answer on the bus
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == bfs_pkg::ADDR_CMD)   || (a == bfs_pkg::ADDR_OPND)  ||
                (a == bfs_pkg::ADDR_SW)    || (a == bfs_pkg::ADDR_PC)    ||
                (a == bfs_pkg::ADDR_IOSEL) || (a == bfs_pkg::ADDR_IODAT) ||
                (a == bfs_pkg::ADDR_STAT);
   endfunction

   // Branch condition for the three conditional branches
   function automatic logic br_cond(input bfs_pkg::bfs_op_t op,
                                    input logic [7:0] sw);
      case (op)
         bfs_pkg::OP_BRANCH_OVERFLOW_CLEAR: br_cond = ~sw[bfs_pkg::SW_V];
         bfs_pkg::OP_BRANCH_IRQ_ON:         br_cond = sw[bfs_pkg::SW_I];
         bfs_pkg::OP_BRANCH_IRQ_OFF:        br_cond = ~sw[bfs_pkg::SW_I];
         default:                           br_cond = 1'b0;
      endcase
   endfunction

   // Shifter and flag datapaths
   bfs_shift_unit u_shift (
      .i_op    (cmd_q.op),
      .i_opnd  (opnd_q),
      .i_carry (sw_q[bfs_pkg::SW_C]),
      .o_shf   (shf)
   );

   bfs_flag_unit u_flag (
      .i_op   (cmd_q.op),
      .i_sel  (cmd_q.bit_sel),
      .i_sw   (sw_q),
      .i_opnd (opnd_q),
      .o_sw   (flag_sw)
   );

   // APB handshake and write qualification
   assign acc       = I_PSEL & I_PENABLE & I_CE;
   assign O_PREADY  = I_PSEL & I_PENABLE & I_CE;
   assign O_PSLVERR = acc & ~addr_ok(I_PADDR);
   assign O_PRDATA  = prdata_q;
   assign O_BUSY    = (st_q != bfs_pkg::ST_IDLE);
   assign wr_ok     = acc & I_PWRITE & (st_q == bfs_pkg::ST_IDLE);
   assign launch    = wr_ok & (I_PADDR == bfs_pkg::ADDR_CMD) &
                      (I_PWDATA[4:0] != bfs_pkg::OP_ILLEGAL);

   // Operation decode and timing class
   assign k_ext   = {{8{cmd_q.ofs[7]}}, cmd_q.ofs};
   assign pc_tgt  = pc_q + k_ext + 16'h0001;
   assign pc_inc  = pc_q + 16'h0001;
   assign taken   = br_cond(cmd_q.op, sw_q);
   assign io_op   = (cmd_q.op == bfs_pkg::OP_IO_BIT_RAISE) |
                    (cmd_q.op == bfs_pkg::OP_IO_BIT_DROP);
   assign shf_op  = (cmd_q.op >= bfs_pkg::OP_SHIFT_LEFT_LOGICAL) &
                    (cmd_q.op <= bfs_pkg::OP_SHIFT_RIGHT_ARITH);
   assign two_cyc = taken | io_op;
   assign commit  = ((st_q == bfs_pkg::ST_EXEC) & ~two_cyc) |
                    (st_q == bfs_pkg::ST_SECOND);

   // Next status word and operand
   always_comb
   begin
      sw_d   = flag_sw;
      opnd_d = opnd_q;
      if (shf_op)
      begin
         sw_d[bfs_pkg::SW_C] = shf.c;
         sw_d[bfs_pkg::SW_Z] = shf.z;
         sw_d[bfs_pkg::SW_N] = shf.n;
         sw_d[bfs_pkg::SW_V] = shf.v;
         opnd_d = shf.res;
      end
      else if (cmd_q.op == bfs_pkg::OP_NIBBLE_SWAP)
         opnd_d = shf.res;
      else if (cmd_q.op == bfs_pkg::OP_T_LOAD)
         opnd_d[cmd_q.bit_sel] = sw_q[bfs_pkg::SW_T];
   end

   // Engine sequencer
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         st_q <= bfs_pkg::ST_IDLE;
      else if (I_CE)
      begin
         unique case (st_q)
            bfs_pkg::ST_IDLE:
               if (launch)
                  st_q <= bfs_pkg::ST_EXEC;
            bfs_pkg::ST_EXEC:
               st_q <= two_cyc ? bfs_pkg::ST_SECOND
                               : bfs_pkg::ST_IDLE;
            bfs_pkg::ST_SECOND:
               st_q <= bfs_pkg::ST_IDLE;
            default:
               st_q <= bfs_pkg::ST_IDLE;
         endcase
      end
   end

   // Command latch
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         cmd_q <= '0;
      else if (I_CE && launch)
         cmd_q <= bfs_pkg::bfs_cmd_t'(I_PWDATA);
   end

   // Program counter
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         pc_q <= bfs_pkg::PC_RST;
      else if (I_CE)
      begin
         if (commit)
            pc_q <= taken ? pc_tgt : pc_inc;
         else if (wr_ok && I_PADDR == bfs_pkg::ADDR_PC)
            pc_q <= I_PWDATA[15:0];
      end
   end

   // Status word
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         sw_q <= bfs_pkg::SW_RST;
      else if (I_CE)
      begin
         if (commit)
            sw_q <= sw_d;
         else if (wr_ok && I_PADDR == bfs_pkg::ADDR_SW)
            sw_q <= I_PWDATA[7:0];
      end
   end

   // Register operand and result
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         opnd_q <= bfs_pkg::OPND_RST;
      else if (I_CE)
      begin
         if (commit)
            opnd_q <= opnd_d;
         else if (wr_ok && I_PADDR == bfs_pkg::ADDR_OPND)
            opnd_q <= I_PWDATA[7:0];
      end
   end

   // I/O space, bit operations write on their second cycle
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         iosel_q <= 5'h00;
         for (int i = 0; i < IO_DEPTH; i++)
            io_mem_q[i] <= 8'h00;
      end
      else if (I_CE)
      begin
         if (commit && io_op)
            io_mem_q[cmd_q.port][cmd_q.bit_sel] <=
               (cmd_q.op == bfs_pkg::OP_IO_BIT_RAISE);
         else if (wr_ok && I_PADDR == bfs_pkg::ADDR_IODAT)
            io_mem_q[iosel_q] <= I_PWDATA[7:0];
         if (wr_ok && I_PADDR == bfs_pkg::ADDR_IOSEL)
            iosel_q <= I_PWDATA[4:0];
      end
   end

   // Record of the last completed operation
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
      begin
         taken_q <= 1'b0;
         cyc_q   <= 2'h0;
      end
      else if (I_CE && commit)
      begin
         taken_q <= taken;
         cyc_q   <= (st_q == bfs_pkg::ST_SECOND) ? bfs_pkg::CYC_TWO
                                                 : bfs_pkg::CYC_ONE;
      end
   end

   // Read data selection
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      unique case (I_PADDR)
         bfs_pkg::ADDR_CMD:   rd_mux = 32'(cmd_q);
         bfs_pkg::ADDR_OPND:  rd_mux = {24'h000000, opnd_q};
         bfs_pkg::ADDR_SW:    rd_mux = {24'h000000, sw_q};
         bfs_pkg::ADDR_PC:    rd_mux = {16'h0000, pc_q};
         bfs_pkg::ADDR_IOSEL: rd_mux = {27'h0000000, iosel_q};
         bfs_pkg::ADDR_IODAT: rd_mux = {24'h000000, io_mem_q[iosel_q]};
         bfs_pkg::ADDR_STAT:
         begin
            rd_mux[bfs_pkg::STAT_BUSY]  = O_BUSY;
            rd_mux[bfs_pkg::STAT_TAKEN] = taken_q;
            rd_mux[bfs_pkg::STAT_CYC +: 2] = cyc_q;
         end
         default:             rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup phase
   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_B)
         prdata_q <= 32'h0000_0000;
      else if (I_CE && I_PSEL && !I_PENABLE)
         prdata_q <= rd_mux;
   end

   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_B || !I_CE);

   // Engine in its first cycle with a given operation
   sequence s_exec(bfs_pkg::bfs_op_t o);
      st_q == bfs_pkg::ST_EXEC && cmd_q.op == o;
   endsequence

   sequence s_two_step;
      st_q == bfs_pkg::ST_SECOND ##1 st_q == bfs_pkg::ST_IDLE;
   endsequence

   a_ovf_br_taken: assert property (
      s_exec(bfs_pkg::OP_BRANCH_OVERFLOW_CLEAR) ##0 !sw_q[bfs_pkg::SW_V]
      |=> s_two_step ##0 pc_q == $past(pc_tgt, 2))
      else $error("overflow branch taken path wrong");

   a_ovf_br_skip: assert property (
      s_exec(bfs_pkg::OP_BRANCH_OVERFLOW_CLEAR) ##0 sw_q[bfs_pkg::SW_V]
      |=> st_q == bfs_pkg::ST_IDLE && pc_q == $past(pc_inc))
      else $error("overflow branch not taken path wrong");

   a_irq_on_br: assert property (
      s_exec(bfs_pkg::OP_BRANCH_IRQ_ON) ##0 sw_q[bfs_pkg::SW_I]
      |=> ##1 pc_q == $past(pc_tgt, 2) && sw_q == $past(sw_q, 2))
      else $error("branch on interrupts enabled wrong");

   a_irq_off_br: assert property (
      s_exec(bfs_pkg::OP_BRANCH_IRQ_OFF) ##0 sw_q[bfs_pkg::SW_I]
      |=> pc_q == $past(pc_inc) && sw_q == $past(sw_q))
      else $error("branch on interrupts disabled taken wrongly");

   a_io_bit_raise: assert property (
      s_exec(bfs_pkg::OP_IO_BIT_RAISE) |=> s_two_step ##0
      io_mem_q[cmd_q.port][cmd_q.bit_sel] && sw_q == $past(sw_q, 2))
      else $error("I/O bit raise wrong");

   a_shift_left: assert property (
      s_exec(bfs_pkg::OP_SHIFT_LEFT_LOGICAL)
      |=> opnd_q == {$past(opnd_q[6:0]), 1'b0} &&
          sw_q[bfs_pkg::SW_C] == $past(opnd_q[7]))
      else $error("logical left shift wrong");

   a_rotate_carry: assert property (
      s_exec(bfs_pkg::OP_ROTATE_RIGHT_CARRY)
      |=> opnd_q[7] == $past(sw_q[bfs_pkg::SW_C]) &&
          sw_q[bfs_pkg::SW_C] == $past(opnd_q[0]))
      else $error("rotate right through carry wrong");

   a_arith_shift: assert property (
      s_exec(bfs_pkg::OP_SHIFT_RIGHT_ARITH)
      |=> opnd_q[7] == $past(opnd_q[7]) &&
          sw_q[bfs_pkg::SW_C] == $past(opnd_q[0]) &&
          sw_q[bfs_pkg::SW_V] == (sw_q[bfs_pkg::SW_N] ^ sw_q[bfs_pkg::SW_C]))
      else $error("arithmetic right shift wrong");

   a_nibble_swap: assert property (
      s_exec(bfs_pkg::OP_NIBBLE_SWAP)
      |=> opnd_q == {$past(opnd_q[3:0]), $past(opnd_q[7:4])} &&
          sw_q == $past(sw_q))
      else $error("nibble exchange wrong");

   a_flag_raise: assert property (
      s_exec(bfs_pkg::OP_STATUS_FLAG_RAISE)
      |=> sw_q == ($past(sw_q) | (8'h01 << $past(cmd_q.bit_sel))))
      else $error("generic flag raise wrong");

   a_t_load: assert property (
      s_exec(bfs_pkg::OP_T_LOAD)
      |=> opnd_q[cmd_q.bit_sel] == $past(sw_q[bfs_pkg::SW_T]) &&
          sw_q == $past(sw_q))
      else $error("T load wrong");

   a_zero_drop: assert property (
      s_exec(bfs_pkg::OP_ZERO_DROP)
      |=> sw_q == ($past(sw_q) & ~(8'h01 << bfs_pkg::SW_Z)))
      else $error("zero flag clear wrong");

   a_irq_raise: assert property (
      s_exec(bfs_pkg::OP_IRQ_RAISE)
      |=> sw_q == ($past(sw_q) | (8'h01 << bfs_pkg::SW_I)))
      else $error("interrupt enable wrong");

   a_one_cycle: assert property (
      st_q == bfs_pkg::ST_EXEC && cmd_q.op >= bfs_pkg::OP_STATUS_FLAG_RAISE
      && cmd_q.op <= bfs_pkg::OP_HALF_DROP |=> st_q == bfs_pkg::ST_IDLE)
      else $error("flag operation not single cycle");
endmodule // bfs_core

/* File: pkg/bfs_pkg.sv */
// Constants and types for the bit, flag and shift execution unit
package bfs_pkg;
   // APB byte offsets
   localparam logic [7:0] ADDR_CMD   = 8'h00;
   localparam logic [7:0] ADDR_OPND  = 8'h04;
   localparam logic [7:0] ADDR_SW    = 8'h08;
   localparam logic [7:0] ADDR_PC    = 8'h0c;
   localparam logic [7:0] ADDR_IOSEL = 8'h10;
   localparam logic [7:0] ADDR_IODAT = 8'h14;
   localparam logic [7:0] ADDR_STAT  = 8'h18;
   // Status word bit positions
   localparam int SW_C = 0;
   localparam int SW_Z = 1;
   localparam int SW_N = 2;
   localparam int SW_V = 3;
   localparam int SW_S = 4;
   localparam int SW_H = 5;
   localparam int SW_T = 6;
   localparam int SW_I = 7;
   // Engine status register fields
   localparam int STAT_BUSY  = 0;
   localparam int STAT_TAKEN = 1;
   localparam int STAT_CYC   = 4;
   // Reset values
   localparam logic [7:0]  SW_RST   = 8'h00;
   localparam logic [15:0] PC_RST   = 16'h0000;
   localparam logic [7:0]  OPND_RST = 8'h00;
   // Cycle counts reported per operation
   localparam logic [1:0] CYC_ONE = 2'h1;
   localparam logic [1:0] CYC_TWO = 2'h2;

   // Operation codes
   typedef enum logic [4:0] {
      OP_BRANCH_OVERFLOW_CLEAR = 5'h00,
      OP_BRANCH_IRQ_ON         = 5'h01,
      OP_BRANCH_IRQ_OFF        = 5'h02,
      OP_IO_BIT_RAISE          = 5'h03,
      OP_IO_BIT_DROP           = 5'h04,
      OP_SHIFT_LEFT_LOGICAL    = 5'h05,
      OP_SHIFT_RIGHT_LOGICAL   = 5'h06,
      OP_ROTATE_LEFT_CARRY     = 5'h07,
      OP_ROTATE_RIGHT_CARRY    = 5'h08,
      OP_SHIFT_RIGHT_ARITH     = 5'h09,
      OP_NIBBLE_SWAP           = 5'h0a,
      OP_STATUS_FLAG_RAISE     = 5'h0b,
      OP_STATUS_FLAG_DROP      = 5'h0c,
      OP_T_STORE               = 5'h0d,
      OP_T_LOAD                = 5'h0e,
      OP_CARRY_RAISE           = 5'h0f,
      OP_CARRY_DROP            = 5'h10,
      OP_NEG_RAISE             = 5'h11,
      OP_NEG_DROP              = 5'h12,
      OP_ZERO_RAISE            = 5'h13,
      OP_ZERO_DROP             = 5'h14,
      OP_IRQ_RAISE             = 5'h15,
      OP_IRQ_DROP              = 5'h16,
      OP_SIGN_RAISE            = 5'h17,
      OP_SIGN_DROP             = 5'h18,
      OP_OVF_RAISE             = 5'h19,
      OP_OVF_DROP              = 5'h1a,
      OP_T_RAISE               = 5'h1b,
      OP_T_DROP                = 5'h1c,
      OP_HALF_RAISE            = 5'h1d,
      OP_HALF_DROP             = 5'h1e,
      OP_ILLEGAL               = 5'h1f
   } bfs_op_t;

   // Command word written to ADDR_CMD
   typedef struct packed {
      logic [10:0] rsvd;
      logic [4:0]  port;
      logic [7:0]  ofs;
      logic [2:0]  bit_sel;
      bfs_op_t     op;
   } bfs_cmd_t;

   // Shifter result with its flags
   typedef struct packed {
      logic [7:0] res;
      logic       c;
      logic       z;
      logic       n;
      logic       v;
   } bfs_shf_t;

   // Engine states
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_EXEC   = 2'b01,
      ST_SECOND = 2'b10
   } bfs_st_t;
endpackage

/* File: src/bfs_shift_unit.sv */
// Shift, rotate and nibble exchange datapath
module bfs_shift_unit (
   input  wire bfs_pkg::bfs_op_t  i_op,    // Operation
   input  wire logic [7:0]        i_opnd,  // Register operand
   input  wire logic              i_carry, // Old carry flag
   output bfs_pkg::bfs_shf_t      o_shf    // Result and flags
);
   // Result and carry per operation
   always_comb
   begin
      o_shf.res = i_opnd;
      o_shf.c   = i_carry;
      unique case (i_op)
         bfs_pkg::OP_SHIFT_LEFT_LOGICAL:
         begin
            o_shf.res = {i_opnd[6:0], 1'b0};
            o_shf.c   = i_opnd[7];
         end
         bfs_pkg::OP_SHIFT_RIGHT_LOGICAL:
         begin
            o_shf.res = {1'b0, i_opnd[7:1]};
            o_shf.c   = i_opnd[0];
         end
         bfs_pkg::OP_ROTATE_LEFT_CARRY:
         begin
            o_shf.res = {i_opnd[6:0], i_carry};
            o_shf.c   = i_opnd[7];
         end
         bfs_pkg::OP_ROTATE_RIGHT_CARRY:
         begin
            o_shf.res = {i_carry, i_opnd[7:1]};
            o_shf.c   = i_opnd[0];
         end
         bfs_pkg::OP_SHIFT_RIGHT_ARITH:
         begin
            o_shf.res = {i_opnd[7], i_opnd[7:1]};
            o_shf.c   = i_opnd[0];
         end
         bfs_pkg::OP_NIBBLE_SWAP:
            o_shf.res = {i_opnd[3:0], i_opnd[7:4]};
         default:
            o_shf.res = i_opnd;
      endcase
      // Flags follow from the result
      o_shf.z = (o_shf.res == 8'h00);
      o_shf.n = o_shf.res[7];
      o_shf.v = o_shf.res[7] ^ o_shf.c;
   end
endmodule // bfs_shift_unit

/* File: src/bfs_flag_unit.sv */
// Status word update for flag and T-bit operations
module bfs_flag_unit (
   input  wire bfs_pkg::bfs_op_t  i_op,   // Operation
   input  wire logic [2:0]        i_sel,  // Bit index s or b
   input  wire logic [7:0]        i_sw,   // Current status word
   input  wire logic [7:0]        i_opnd, // Register operand
   output logic      [7:0]        o_sw    // Next status word
);
   logic [4:0] rel;

   // Status bit owned by each dedicated operation pair
   function automatic logic [2:0] fixed_bit(input logic [3:0] pair);
      case (pair)
         4'h0:    fixed_bit = 3'(bfs_pkg::SW_C);
         4'h1:    fixed_bit = 3'(bfs_pkg::SW_N);
         4'h2:    fixed_bit = 3'(bfs_pkg::SW_Z);
         4'h3:    fixed_bit = 3'(bfs_pkg::SW_I);
         4'h4:    fixed_bit = 3'(bfs_pkg::SW_S);
         4'h5:    fixed_bit = 3'(bfs_pkg::SW_V);
         4'h6:    fixed_bit = 3'(bfs_pkg::SW_T);
         default: fixed_bit = 3'(bfs_pkg::SW_H);
      endcase
   endfunction

   assign rel = i_op - bfs_pkg::OP_CARRY_RAISE;

   // One status bit written, the rest kept
   always_comb
   begin
      o_sw = i_sw;
      if (i_op == bfs_pkg::OP_STATUS_FLAG_RAISE)
         o_sw[i_sel] = 1'b1;
      else if (i_op == bfs_pkg::OP_STATUS_FLAG_DROP)
         o_sw[i_sel] = 1'b0;
      else if (i_op == bfs_pkg::OP_T_STORE)
         o_sw[bfs_pkg::SW_T] = i_opnd[i_sel];
      else if (i_op >= bfs_pkg::OP_CARRY_RAISE &&
               i_op <= bfs_pkg::OP_HALF_DROP)
         o_sw[fixed_bit(rel[4:1])] = ~rel[0];
   end
endmodule // bfs_flag_unit

/* File: testbench/tb_bit_flag_shift_ops.sv */
// Self-checking bench for the bit, flag and shift execution unit
`define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin \
   failures++; $display("unexpected %s exp %h got %h", nm, e, s); end end

module tb_bit_flag_shift_ops;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk, i_rst_b, i_ce, psel, penable, pwrite, cont, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rdata, stat, prdata;
   logic        pready, pslverr, busy;
   int          failures, total_checks, cycles;

   bfs_core #(.IO_DEPTH(32)) i_bfs_core (
      .I_CLK(i_clk), .I_RST_B(i_rst_b), .I_CE(i_ce), .I_PSEL(psel),
      .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
      .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .O_BUSY(busy));

   // Core clock, 4 ns period
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // Hang guard
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         end_sim;
      end
   end

   task automatic end_sim;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // One APB transfer; more keeps psel up for a chained setup
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input bit more);
      if (!cont)
         @(posedge i_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      do
         @(posedge i_clk);
      while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      // A chained call lowers penable itself in its setup cycle
      if (!more)
      begin
         psel    <= 1'b0;
         penable <= 1'b0;
      end
      cont = more;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 1'b0);
   endtask

   // Wait until the engine reports idle, keep its status
   task automatic wait_idle;
      do
         rd(bfs_pkg::ADDR_STAT);
      while (rdata[bfs_pkg::STAT_BUSY] !== 1'b0);
      stat = rdata;
   endtask

   task automatic run(input logic [4:0] o, input logic [2:0] b,
                      input logic [7:0] k, input logic [4:0] p);
      wr(bfs_pkg::ADDR_CMD, {11'h0, p, k, b, o});
      wait_idle;
   endtask

   // Launch op from given status word and operand, check both after
   task automatic opchk(input logic [4:0] o, input logic [2:0] b,
                        input logic [7:0] sw, input logic [7:0] v,
                        input logic [7:0] esw, input logic [7:0] ev);
      wr(bfs_pkg::ADDR_SW, {24'h0, sw});
      wr(bfs_pkg::ADDR_OPND, {24'h0, v});
      run(o, b, 8'h00, 5'h00);
      rd(bfs_pkg::ADDR_SW);
      `CHK("sw", {24'h0, esw}, rdata)
      rd(bfs_pkg::ADDR_OPND);
      `CHK("opnd", {24'h0, ev}, rdata)
      `CHK("cycles", bfs_pkg::CYC_ONE, stat[5:4])
   endtask

   task automatic t_shift;
      logic [7:0] v, r;
      logic       ci, c, n;
      for (int o = 5; o <= 9; o++)
         for (int j = 0; j < 4; j++)
         begin
            v = j[1] ? 8'h81 : 8'h01;
            ci = j[0];
            case (o)
               5: {c, r} = {v, 1'b0};
               6: {r, c} = {1'b0, v};
               7: {c, r} = {v, ci};
               8: {r, c} = {ci, v};
               default: {r, c} = {v[7], v};
            endcase
            n = r[7];
            opchk(o[4:0], 3'h0, {4'h5, 3'h0, ci}, v,
                  {4'h5, n ^ c, n, r == 8'h00, c}, r);
         end
      opchk(5'h0a, 3'h0, 8'h3c, 8'hb4, 8'h3c, 8'h4b);
      $display("shift test done");
   endtask

   task automatic t_branch;
      logic [7:0]  sw, k;
      logic [15:0] pc;
      logic        tk;
      for (int o = 0; o <= 2; o++)
         for (int f = 0; f <= 1; f++)
         begin
            sw = 8'h35 | (f[0] << ((o == 0) ? 3 : 7));
            k = f[0] ? 8'h7f : 8'hfd;
            tk = (o == 1) ? f[0] : !f[0];
            pc = tk ? 16'h0101 + {{8{k[7]}}, k} : 16'h0101;
            wr(bfs_pkg::ADDR_SW, {24'h0, sw});
            wr(bfs_pkg::ADDR_PC, 32'h100);
            run(o[4:0], 3'h0, k, 5'h00);
            `CHK("taken", tk, stat[bfs_pkg::STAT_TAKEN])
            `CHK("bcyc", tk ? 2'h2 : 2'h1, stat[5:4])
            rd(bfs_pkg::ADDR_PC);
            `CHK("pc", {16'h0, pc}, rdata)
            rd(bfs_pkg::ADDR_SW);
            `CHK("bsw", {24'h0, sw}, rdata)
         end
      $display("branch test done");
   endtask

   task automatic t_io;
      wr(bfs_pkg::ADDR_SW, 32'ha5);
      wr(bfs_pkg::ADDR_IOSEL, 32'h1f);
      wr(bfs_pkg::ADDR_IODAT, 32'h0f);
      for (int i = 0; i < 2; i++)
      begin
         run(i ? 5'h04 : 5'h03, i ? 3'h0 : 3'h6, 8'h00, 5'h1f);
         `CHK("iocyc", bfs_pkg::CYC_TWO, stat[5:4])
         rd(bfs_pkg::ADDR_IODAT);
         `CHK("io", i ? 32'h4e : 32'h4f, rdata)
      end
      rd(bfs_pkg::ADDR_SW);
      `CHK("iosw", 32'ha5, rdata)
      // Busy engine drops a chained write to the status word
      apb(1'b1, bfs_pkg::ADDR_CMD, {11'h0, 5'h1f, 8'h0, 3'h7, 5'h03}, 1);
      apb(1'b1, bfs_pkg::ADDR_SW, 32'h00, 0);
      wait_idle;
      rd(bfs_pkg::ADDR_SW);
      `CHK("drop", 32'ha5, rdata)
      rd(bfs_pkg::ADDR_IODAT);
      `CHK("io7", 32'hce, rdata)
      rd(8'h1c);
      `CHK("unmapped", 33'h1_0000_0000, {err, rdata})
      $display("io test done");
   endtask

   task automatic t_flags;
      int         p[8] = '{0, 2, 1, 7, 4, 3, 6, 5};
      logic [7:0] m, s0;
      for (int s = 0; s < 8; s++)
      begin
         m = 8'h01 << s;
         opchk(5'h0b, s[2:0], 8'h00, 8'h00, m, 8'h00);
         opchk(5'h0c, s[2:0], 8'hff, 8'h00, ~m, 8'h00);
      end
      for (int i = 0; i < 16; i++)
      begin
         m = 8'h01 << p[i / 2];
         s0 = i[0] ? 8'h5a | m : 8'h5a & ~m;
         opchk(5'h0f + i[4:0], 3'h0, s0, 8'h00, s0 ^ m, 8'h00);
      end
      opchk(5'h0d, 3'h5, 8'hbf, 8'h20, 8'hff, 8'h20);
      opchk(5'h0d, 3'h5, 8'h40, 8'hdf, 8'h00, 8'hdf);
      opchk(5'h0e, 3'h3, 8'h40, 8'h00, 8'h40, 8'h08);
      opchk(5'h0e, 3'h0, 8'hbf, 8'hff, 8'hbf, 8'hfe);
      $display("flag test done");
   endtask

   // Low clock enable holds a running two-cycle operation in place
   task automatic t_ce;
      wr(bfs_pkg::ADDR_CMD, {11'h0, 5'h1f, 8'h0, 3'h0, 5'h03});
      i_ce <= 1'b0;
      repeat (4) @(posedge i_clk);
      `CHK("ce_busy", 1'b1, busy)
      i_ce <= 1'b1;
      wait_idle;
      `CHK("ce_cyc", bfs_pkg::CYC_TWO, stat[5:4])
      rd(bfs_pkg::ADDR_IODAT);
      `CHK("ce_io", 32'hcf, rdata)
      $display("enable test done");
   endtask

   // Main sequence
   initial
   begin
      {psel, penable, pwrite, cont} = 4'h0;
      i_ce = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      i_rst_b = 1'b0;
      repeat (6) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rd(bfs_pkg::ADDR_SW);
      `CHK("rst_sw", 32'h0, rdata)
      rd(bfs_pkg::ADDR_PC);
      `CHK("rst_pc", 32'h0, rdata)
      t_shift;
      t_branch;
      t_io;
      t_ce;
      t_flags;
      end_sim;
   end
endmodule // tb_bit_flag_shift_ops
